// [include/port_pin_map.vh]
// Constants for the per-pin port configuration block.
// Assumes a 16-pin port on one synchronous clock.
`ifndef PORT_PIN_MAP_VH
`define PORT_PIN_MAP_VH

`define PORT_WIDTH 16
`define ANALOG_SELECT_RESET 16'hFFFF
`define PIN_DIRECTION_RESET 16'hFFFF
`define OUTPUT_LATCH_RESET 16'h0000
`define OPEN_DRAIN_RESET 16'h0000
`define PIN_STATE_RESET 16'h0000
`define ANALOG_LEVEL_RESET 16'h0000

`endif

// [rtl/pin_sync.v]
// Two-stage synchroniser for the digital pin inputs.
// Assumes pins are sampled on clk_sys; first stage feeds only the second.
`timescale 1ns/1ps
`include "port_pin_map.vh"

module pin_sync (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Data
   input wire [`PORT_WIDTH-1:0] async_in,
   output reg [`PORT_WIDTH-1:0] sync_out
);

   reg [`PORT_WIDTH-1:0] meta_q;

   always @(posedge clk_sys) begin
      if (rst) begin
         meta_q <= `PIN_STATE_RESET;
         sync_out <= `PIN_STATE_RESET;
      end else begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule // pin_sync

// [rtl/port_pin_config.v]
// Per-pin configuration, drive and read-back logic of a 16-pin port.
// Holds the four control registers, the pad drive, the synchronised
// read-back and the routing of pin levels to the analog peripherals.
// Assumes the core writes the control registers through write strobes,
// and that pads resolve the pin level from pin_out and pin_oe.
// Assumes software allows the full read-back latency after a write.
`timescale 1ns/1ps
`include "port_pin_map.vh"

////////////////////////////////////////////////////////////////////////////
module port_pin_config (
   // Clock and reset
   input wire clk_sys,
   input wire rst,
   // Register writes from the core
   input wire open_drain_select_we,
   input wire analog_select_we,
   input wire pin_direction_we,
   input wire output_latch_we,
   input wire [`PORT_WIDTH-1:0] wr_data,
   // Register read-back to the core
   output wire [`PORT_WIDTH-1:0] open_drain_select,
   output wire [`PORT_WIDTH-1:0] analog_select,
   output wire [`PORT_WIDTH-1:0] pin_direction,
   output wire [`PORT_WIDTH-1:0] output_latch,
   output wire [`PORT_WIDTH-1:0] pin_state,
   // Pads
   input wire [`PORT_WIDTH-1:0] pin_in,
   output wire [`PORT_WIDTH-1:0] pin_out,
   output wire [`PORT_WIDTH-1:0] pin_oe,
   // Analog peripherals
   input wire [`PORT_WIDTH-1:0] analog_pin_level,
   output wire [`PORT_WIDTH-1:0] analog_level,
   output wire [`PORT_WIDTH-1:0] analog_enable
);

   ////////////////////////////////////////////////////////////////////////
   // Internal state

   // Control registers and their next values
   reg [`PORT_WIDTH-1:0] open_drain_select_q;
   reg [`PORT_WIDTH-1:0] open_drain_select_d;

   reg [`PORT_WIDTH-1:0] analog_select_q;
   reg [`PORT_WIDTH-1:0] analog_select_d;

   reg [`PORT_WIDTH-1:0] pin_direction_q;
   reg [`PORT_WIDTH-1:0] pin_direction_d;

   reg [`PORT_WIDTH-1:0] output_latch_q;
   reg [`PORT_WIDTH-1:0] output_latch_d;

   // Read-back and analog registers
   reg [`PORT_WIDTH-1:0] pin_state_q;
   reg [`PORT_WIDTH-1:0] pin_state_d;

   reg [`PORT_WIDTH-1:0] analog_level_q;
   reg [`PORT_WIDTH-1:0] analog_level_d;

   // Synchronised pins and derived per-pin masks
   wire [`PORT_WIDTH-1:0] pin_sync_q;
   wire [`PORT_WIDTH-1:0] drive_out;
   wire [`PORT_WIDTH-1:0] analog_in_pins;
   wire [`PORT_WIDTH-1:0] analog_out_pins;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Next value of a register that loads whole words on its strobe
   function [`PORT_WIDTH-1:0] write_merge;
      input load;
      input [`PORT_WIDTH-1:0] current;
      input [`PORT_WIDTH-1:0] data;
      begin
         if (load) begin
            write_merge = data;
         end else begin
            write_merge = current;
         end
      end
   endfunction

   // Pins that are analog and set as inputs
   function [`PORT_WIDTH-1:0] analog_in_mask;
      input [`PORT_WIDTH-1:0] sel;
      input [`PORT_WIDTH-1:0] dir;
      begin
         analog_in_mask = sel & dir;
      end
   endfunction

   // Pins that are analog and set as outputs
   function [`PORT_WIDTH-1:0] analog_out_mask;
      input [`PORT_WIDTH-1:0] sel;
      input [`PORT_WIDTH-1:0] dir;
      begin
         analog_out_mask = sel & ~dir;
      end
   endfunction

   // Clears every bit of a word that the mask marks
   function [`PORT_WIDTH-1:0] mask_low;
      input [`PORT_WIDTH-1:0] value;
      input [`PORT_WIDTH-1:0] mask;
      begin
         mask_low = value & ~mask;
      end
   endfunction

   // Level handed to the converter: own drive or pad level, else zero
   function [`PORT_WIDTH-1:0] route_analog;
      input [`PORT_WIDTH-1:0] out_pins;
      input [`PORT_WIDTH-1:0] in_pins;
      input [`PORT_WIDTH-1:0] latch;
      input [`PORT_WIDTH-1:0] level;
      begin
         route_analog = (out_pins & latch) | (in_pins & level);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Control registers

   always @* begin
      open_drain_select_d = write_merge(open_drain_select_we,
         open_drain_select_q, wr_data);
      analog_select_d = write_merge(analog_select_we,
         analog_select_q, wr_data);
      pin_direction_d = write_merge(pin_direction_we,
         pin_direction_q, wr_data);
      output_latch_d = write_merge(output_latch_we,
         output_latch_q, wr_data);
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         open_drain_select_q <= `OPEN_DRAIN_RESET;
         analog_select_q <= `ANALOG_SELECT_RESET;
         pin_direction_q <= `PIN_DIRECTION_RESET;
         output_latch_q <= `OUTPUT_LATCH_RESET;
      end else begin
         open_drain_select_q <= open_drain_select_d;
         analog_select_q <= analog_select_d;
         pin_direction_q <= pin_direction_d;
         output_latch_q <= output_latch_d;
      end
   end

   // Register read-back
   assign open_drain_select = open_drain_select_q;
   assign analog_select = analog_select_q;
   assign pin_direction = pin_direction_q;
   assign output_latch = output_latch_q;

   ////////////////////////////////////////////////////////////////////////
   // Pad drive

   // A set direction bit leaves the pad to the outside world
   assign drive_out = ~pin_direction_q;

   // Open drain never drives high; it releases the pad instead
   assign pin_out = mask_low(output_latch_q, open_drain_select_q);
   assign pin_oe = mask_low(drive_out,
      open_drain_select_q & output_latch_q);

   ////////////////////////////////////////////////////////////////////////
   // Input path

   // Pins cross into clk_sys through two flops
   pin_sync u_pin_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in(pin_in),
      .sync_out(pin_sync_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // Analog routing and read-back

   assign analog_in_pins = analog_in_mask(analog_select_q,
      pin_direction_q);
   assign analog_out_pins = analog_out_mask(analog_select_q,
      pin_direction_q);

   always @* begin
      // Analog inputs read low
      pin_state_d = mask_low(pin_sync_q, analog_in_pins);
      // Digital pins get nothing; analog inputs hand their pad level and analog outputs their output latch to the converter
      analog_level_d = route_analog(analog_out_pins, analog_in_pins,
         output_latch_q, analog_pin_level);
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         pin_state_q <= `PIN_STATE_RESET;
         analog_level_q <= `ANALOG_LEVEL_RESET;
      end else begin
         pin_state_q <= pin_state_d;
         analog_level_q <= analog_level_d;
      end
   end

   assign pin_state = pin_state_q;
   assign analog_level = analog_level_q;

   // Digital pins are cut from the converter
   assign analog_enable = analog_select_q;

endmodule // port_pin_config

// [verification/pad_model.sv]
// Pad model: block drive wins at pin_in, otherwise the outside level is seen; analog_pin_level is the inverted outside level.
`timescale 1ns/1ps
module pad_model (input wire [15:0] pin_out, pin_oe, ext,
   output wire [15:0] pin_in, analog_pin_level);
   assign pin_in = pin_oe & pin_out | ~pin_oe & ext;
   assign analog_pin_level = ~ext;
endmodule // pad_model

// [verification/port_pin_config_chk.sv]
// Checker on the port pins; assumes the single clk_sys domain.
`timescale 1ns/1ps
module port_pin_config_chk (input wire clk_sys, rst,
   input wire [15:0] open_drain_select, analog_select, pin_direction,
   input wire [15:0] output_latch, pin_state, pin_in, pin_out, pin_oe,
   input wire [15:0] analog_level);
   wire [15:0] ain = analog_select & pin_direction;
   wire [15:0] aout = analog_select & ~pin_direction;
   reg [1:0] n_q = 2'h0;
   always @(posedge clk_sys) n_q <= rst ? 2'h0 : n_q + {1'b0, ~&n_q};
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_od_drive: assert property (!(pin_out & open_drain_select))
      else $error("od drive");
   a_reset_analog: assert property ($past(rst) |-> &analog_select)
      else $error("reset");
   a_analog_out: assert property (!($past(aout) &
      (analog_level ^ $past(output_latch)))) else $error("aout");
   a_analog_zero: assert property (!(pin_state & $past(ain)))
      else $error("ain");
   a_digital_iso: assert property (
      !(analog_level & $past(~analog_select))) else $error("dig");
   a_dir_drive: assert property (!(pin_oe & pin_direction))
      else $error("dir");
   a_sync_read: assert property (&n_q |->
      pin_state == ($past(pin_in, 3) & ~$past(ain))) else $error("sync");
   cover property (|pin_state);
   cover property (|(aout & analog_level));
   cover property (|(open_drain_select & output_latch & ~pin_direction));
endmodule // port_pin_config_chk
bind port_pin_config port_pin_config_chk chk (.*);

// [verification/port_pin_config_tb.sv]
// Bench: random setups; every output checked against queues of notes.
// Assumes the pad model on the far side and the single clock clk_sys.
`timescale 1ns/1ps
module port_pin_config_tb;
   reg clk_sys = 1'b0, rst = 1'b1, rd = 1'b0;
   reg [3:0] we = 4'h0;
   reg [15:0] wr_data = 16'h0000, v [0:4];
   reg [31:0] s = 32'h261b_6bce;
   wire [15:0] open_drain_select, analog_select, pin_direction, pin_oe,
      output_latch, pin_state, pin_in, pin_out, analog_pin_level,
      analog_level, analog_enable;
   reg [15:0] q_state [$];
   reg [31:0] q_drive [$], q_analog [$];
   reg [63:0] q_regs [$];
   integer err_count = 0, compares = 0, i, k;
   always #5 clk_sys = ~clk_sys;
   port_pin_config dut (.clk_sys(clk_sys), .rst(rst),
      .open_drain_select_we(we[0]), .analog_select_we(we[1]),
      .pin_direction_we(we[2]), .output_latch_we(we[3]),
      .wr_data(wr_data), .open_drain_select(open_drain_select),
      .analog_select(analog_select), .pin_direction(pin_direction),
      .output_latch(output_latch), .pin_state(pin_state),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .analog_pin_level(analog_pin_level), .analog_level(analog_level),
      .analog_enable(analog_enable));
   pad_model pad (.pin_out(pin_out), .pin_oe(pin_oe), .ext(v[4]),
      .pin_in(pin_in), .analog_pin_level(analog_pin_level));
   function [31:0] xs(input [31:0] a);
      xs = a ^ a << 13;
      xs = xs ^ xs >> 17;
      xs = xs ^ xs << 5;
   endfunction
   task tally(input bad, input [63:0] what);
      compares = compares + 1;
      if (bad) begin
         err_count = err_count + 1;
         $display("mismatch %0t %0s", $time, what);
      end
   endtask
   task check_state(input [15:0] g, e);
      tally(g !== e, "state");
   endtask
   task check_drive(input [31:0] g, e);
      tally(g !== e, "drive");
   endtask
   task check_analog(input [31:0] g, e);
      tally(g !== e, "analog");
   endtask
   task check_regs(input [63:0] g, e);
      tally(g !== e, "regs");
   endtask
   task note_and_read;
      q_state.push_back(~(v[1] & v[2]) & (v[2] & v[4] | ~v[2] & v[3] &
         (~v[0] | v[4])));
      q_drive.push_back({~v[2] & ~(v[0] & v[3]), v[3] & ~v[0]});
      q_analog.push_back({v[1], v[1] & (~v[2] & v[3] | v[2] & ~v[4])});
      q_regs.push_back({v[0], v[1], v[2], v[3]});
      rd = 1'b1;
      @(negedge clk_sys) rd = 1'b0;
   endtask
   task finish_test;
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      if (rd) begin
         check_state(pin_state, q_state.pop_front());
         check_drive({pin_oe, pin_out},
            q_drive.pop_front());
         check_analog({analog_enable, analog_level},
            q_analog.pop_front());
         check_regs({open_drain_select, analog_select,
            pin_direction, output_latch}, q_regs.pop_front());
      end
   end
   initial begin
      v[0] = 16'h0000;
      v[1] = 16'hFFFF;
      v[2] = 16'hFFFF;
      v[3] = 16'h0000;
      v[4] = 16'h0000;
      repeat (12) @(negedge clk_sys);
      rst = 1'b0;
      repeat (4) @(negedge clk_sys);
      note_and_read;
      $display("test reset done");
      for (i = 0; i < 40; i = i + 1) begin
         for (k = 0; k < 5; k = k + 1) begin
            s = xs(s);
            v[k] = s[15:0];
            @(negedge clk_sys) we = 4'h1 << k;
            wr_data = v[k];
         end
         repeat (4) @(negedge clk_sys);
         note_and_read;
         $display("test %0d done", i);
      end
      finish_test;
   end
endmodule // port_pin_config_tb
